// file: src/adc_sched.sv
/*
  scheduler of scan, level 2 and level 1 conversions with scan and prioritized
  result buffers and the scan interrupt.
  assumes the analog core sits on clk, takes start and abort pulses, and returns
  exactly one done pulse per unaborted start; trigger pins are asynchronous.
*/
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// result buffer
// ----------------------------------------------------------------
module adc_fifo
  import adc_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic push,
  input wire logic [31:0] din,
  input wire logic pop,
  // state
  output logic [31:0] dout,
  output logic empty,
  output logic full,
  output logic ovf,
  output logic wr_ok,
  output logic [AW:0] fill_nxt
);
  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ovf;
  } adc_fifo_st_s;

  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_C = (AW+1)'(1);

  adc_fifo_st_s q_ff;
  adc_fifo_st_s nxt_q;

  always_comb begin
    nxt_q = q_ff;
    wr_ok = 1'b0;
    if (clr) begin
      nxt_q.wp = '0;
      nxt_q.rp = '0;
      nxt_q.cnt = '0;
      nxt_q.ovf = 1'b0;
    end else begin
      if (pop && q_ff.cnt != '0) begin
        nxt_q.rp = q_ff.rp + 1'b1;
        nxt_q.cnt = nxt_q.cnt - ONE_C;
      end
      if (push) begin
        if (nxt_q.cnt == DEPTH_C) begin
          nxt_q.ovf = 1'b1;
        end else begin
          nxt_q.mem[q_ff.wp] = din;
          nxt_q.wp = q_ff.wp + 1'b1;
          nxt_q.cnt = nxt_q.cnt + ONE_C;
          wr_ok = 1'b1;
        end
      end
    end
    fill_nxt = nxt_q.cnt;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign dout = q_ff.mem[q_ff.rp];
  assign empty = (q_ff.cnt == '0);
  assign full = (q_ff.cnt == DEPTH_C);
  assign ovf = q_ff.ovf;
endmodule : adc_fifo

// ----------------------------------------------------------------
// scheduler top
// ----------------------------------------------------------------
module adc_sched
  import adc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire adc_bus_s bus_i,
  output logic [31:0] rdata_o,
  // trigger pins
  input wire logic ext_trig_n_i,
  input wire logic scan_tmr_i,
  input wire logic prio_tmr_i,
  // analog core
  output adc_conv_req_s conv_o,
  input wire adc_conv_rsp_s conv_i,
  // interrupt request
  output logic scan_irq_o
);
  adc_st_s q_ff;
  adc_st_s nxt_q;

  logic [31:0] s_dout;
  logic s_empty;
  logic s_full;
  logic s_ovf;
  logic s_wr_ok;
  logic [SCAN_AW:0] s_fill;
  logic [31:0] p_dout;
  logic p_empty;
  logic p_full;
  logic p_ovf;
  logic s_push;
  logic p_push;
  logic s_pop;
  logic p_pop;
  logic s_clr;
  logic p_clr;
  logic [31:0] entry;

  // lowest selected channel at or above a start index
  function automatic logic [CH_W:0] first_sel(input logic [CH_N-1:0] sel,
                                              input logic [CH_W:0] from);
    logic [CH_W:0] r;
    r = '0;
    for (int i = CH_N - 1; i >= 0; i--) begin
      if (sel[i] && (CH_W+1)'(i) >= from) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction : first_sel

  // a read that shifts: top byte, upper half or whole word
  function automatic logic shifts(input logic [1:0] size, input logic [1:0] lane);
    return (size == SZ_WORD)
        || (size == SZ_HALF && lane[1])
        || (size == SZ_BYTE && lane == LANE_TOP);
  endfunction : shifts

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ext_fall;
    logic scan_rise;
    logic prio_rise;
    logic wr_sc;
    logic wr_pc;
    logic wr_ir;
    logic scan_evt;
    logic l1_evt;
    logic l2_evt;
    logic done;
    logic restart;
    logic [CH_W:0] fs;
    adc_lvl_e want;
    logic [CH_W-1:0] want_ch;
    nxt_q = q_ff;
    ext_fall = 1'b0;
    scan_rise = 1'b0;
    prio_rise = 1'b0;
    wr_sc = 1'b0;
    wr_pc = 1'b0;
    wr_ir = 1'b0;
    scan_evt = 1'b0;
    l1_evt = 1'b0;
    l2_evt = 1'b0;
    done = 1'b0;
    restart = 1'b0;
    fs = '0;
    want = LV_IDLE;
    want_ch = '0;
    s_push = 1'b0;
    p_push = 1'b0;
    entry = '0;
    nxt_q.conv.start = 1'b0;
    nxt_q.conv.abort = 1'b0;
    nxt_q.rdata = '0;

    // pin synchronisers and edges
    nxt_q.sy1 = {prio_tmr_i, scan_tmr_i, ext_trig_n_i};
    nxt_q.sy2 = q_ff.sy1;
    nxt_q.prv = q_ff.sy2;
    ext_fall = q_ff.prv[0] & ~q_ff.sy2[0];
    scan_rise = q_ff.sy2[1] & ~q_ff.prv[1];
    prio_rise = q_ff.sy2[2] & ~q_ff.prv[2];

    // register writes
    wr_sc = bus_i.wr && bus_i.addr == OFS_SCAN_CTL;
    wr_pc = bus_i.wr && bus_i.addr == OFS_PRIO_CTL;
    wr_ir = bus_i.wr && bus_i.addr == OFS_IRQ;
    if (wr_sc) begin
      nxt_q.sc_tmr_en = bus_i.wdata[SC_TMR_EN];
      nxt_q.sc_rpt = bus_i.wdata[SC_RPT];
    end
    if (wr_pc) begin
      nxt_q.pc_tmr_en = bus_i.wdata[PC_TMR_EN];
      nxt_q.pc_ext_en = bus_i.wdata[PC_EXT_EN];
      nxt_q.l1_ch = bus_i.wdata[PC_L1CH_LSB +: L1_CH_W];
      nxt_q.l2_ch = bus_i.wdata[PC_L2CH_LSB +: CH_W];
    end
    if (bus_i.wr && bus_i.addr == OFS_SCAN_SEL) begin
      nxt_q.sel = bus_i.wdata;
    end
    if (bus_i.wr && bus_i.addr == OFS_STAGE) begin
      nxt_q.stage = bus_i.wdata[STG_W-1:0];
    end
    if (wr_ir) begin
      nxt_q.irq_en = bus_i.wdata[IR_EN];
    end
    scan_evt = (wr_sc && bus_i.wdata[SC_START]) || (q_ff.sc_tmr_en && scan_rise);
    l1_evt = q_ff.pc_ext_en && ext_fall;
    l2_evt = (wr_pc && bus_i.wdata[PC_START]) || (q_ff.pc_tmr_en && prio_rise);

    // completion of the running conversion
    done = conv_i.done && q_ff.cur != LV_IDLE;
    entry[D_RES_LSB +: RES_W] = conv_i.result;
    entry[D_CH_LSB +: CH_W] = q_ff.conv.ch;
    if (done) begin
      nxt_q.cur = LV_IDLE;
      case (q_ff.cur)
        LV_L1: begin
          nxt_q.l1_req = 1'b0;
          entry[D_SRC_LSB +: 2] = SRC_EXT;
          p_push = 1'b1;
        end
        LV_L2: begin
          nxt_q.l2_req = 1'b0;
          entry[D_SRC_LSB +: 2] = q_ff.l2_src;
          p_push = 1'b1;
        end
        LV_SCAN: begin
          entry[D_SRC_LSB +: 2] = q_ff.scan_src;
          s_push = 1'b1;
          fs = first_sel(q_ff.sel, {1'b0, q_ff.scan_ch} + 1'b1);
          if (!fs[CH_W] && q_ff.sc_rpt) begin
            fs = first_sel(q_ff.sel, '0);
          end
          if (fs[CH_W]) begin
            nxt_q.scan_ch = fs[CH_W-1:0];
          end else begin
            nxt_q.scan_run = 1'b0;
          end
        end
        default: begin
          nxt_q.cur = LV_IDLE;
        end
      endcase
    end

    // activations; level 1 or level 2 already running or held ignores its own, a scan restarts
    if (l1_evt && !q_ff.l1_req) begin
      nxt_q.l1_req = 1'b1;
    end
    if (l2_evt && !q_ff.l2_req) begin
      nxt_q.l2_req = 1'b1;
      nxt_q.l2_src = (wr_pc && bus_i.wdata[PC_START]) ? SRC_SW : SRC_TMR;
    end
    if (scan_evt) begin
      fs = first_sel(q_ff.sel, '0);
      if (fs[CH_W]) begin
        nxt_q.scan_run = 1'b1;
        nxt_q.scan_ch = fs[CH_W-1:0];
        nxt_q.scan_src = (wr_sc && bus_i.wdata[SC_START]) ? SRC_SW : SRC_TMR;
        restart = (q_ff.cur == LV_SCAN) && !done;
      end
    end

    // pick the highest pending level
    if (nxt_q.l1_req) begin
      want = LV_L1;
      want_ch = CH_W'(nxt_q.l1_ch);
    end else if (nxt_q.l2_req) begin
      want = LV_L2;
      want_ch = nxt_q.l2_ch;
    end else if (nxt_q.scan_run) begin
      want = LV_SCAN;
      want_ch = nxt_q.scan_ch;
    end
    if (!done && (want != q_ff.cur || restart)) begin
      nxt_q.conv.abort = (q_ff.cur != LV_IDLE);
      nxt_q.cur = want;
      if (want != LV_IDLE) begin
        nxt_q.conv.start = 1'b1;
        nxt_q.conv.ch = want_ch;
      end
    end

    // scan interrupt flag; a set beats a clear in the same cycle
    if (wr_ir && bus_i.wdata[IR_FLAG]) begin
      nxt_q.irq_flag = 1'b0;
    end
    if (s_wr_ok && s_fill == {1'b0, q_ff.stage} + 1'b1) begin
      nxt_q.irq_flag = 1'b1;
    end

    // read data, valid only in the cycle after the strobe
    // any lane of a word returns the whole word
    if (bus_i.rd) begin
      case ({bus_i.addr[ADDR_W-1:2], 2'b00})
        OFS_STATUS: begin
          nxt_q.rdata[ST_HELD] = q_ff.l1_req & q_ff.l2_req;
          nxt_q.rdata[ST_PRIO] = q_ff.l1_req | q_ff.l2_req;
          nxt_q.rdata[ST_SCAN] = q_ff.scan_run | (q_ff.cur == LV_SCAN);
          nxt_q.rdata[ST_SCAN_EMPTY_FLAG] = s_empty;
          nxt_q.rdata[ST_SCAN_FULL_FLAG] = s_full;
          nxt_q.rdata[ST_SCAN_OVERFLOW_FLAG] = s_ovf;
          nxt_q.rdata[ST_PEMP] = p_empty;
          nxt_q.rdata[ST_PFUL] = p_full;
          nxt_q.rdata[ST_POVR] = p_ovf;
        end
        OFS_SCAN_CTL: begin
          nxt_q.rdata[SC_TMR_EN] = q_ff.sc_tmr_en;
          nxt_q.rdata[SC_RPT] = q_ff.sc_rpt;
        end
        OFS_PRIO_CTL: begin
          nxt_q.rdata[PC_TMR_EN] = q_ff.pc_tmr_en;
          nxt_q.rdata[PC_EXT_EN] = q_ff.pc_ext_en;
          nxt_q.rdata[PC_L1CH_LSB +: L1_CH_W] = q_ff.l1_ch;
          nxt_q.rdata[PC_L2CH_LSB +: CH_W] = q_ff.l2_ch;
        end
        OFS_SCAN_SEL: begin
          nxt_q.rdata = q_ff.sel;
        end
        OFS_STAGE: begin
          nxt_q.rdata[STG_W-1:0] = q_ff.stage;
        end
        OFS_IRQ: begin
          nxt_q.rdata[IR_FLAG] = q_ff.irq_flag;
          nxt_q.rdata[IR_EN] = q_ff.irq_en;
        end
        OFS_SCAN_DATA: begin
          nxt_q.rdata = s_empty ? '0 : s_dout;
        end
        OFS_PRIO_DATA: begin
          nxt_q.rdata = p_empty ? '0 : p_dout;
        end
        default: begin
          nxt_q.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // buffer controls
  // ----------------------------------------------------------------
  assign s_clr = bus_i.wr && bus_i.addr == OFS_SCAN_CTL && bus_i.wdata[SC_CLR];
  assign p_clr = bus_i.wr && bus_i.addr == OFS_PRIO_CTL && bus_i.wdata[PC_CLR];
  assign s_pop = bus_i.rd && bus_i.addr[ADDR_W-1:2] == OFS_SCAN_DATA[ADDR_W-1:2]
                 && shifts(bus_i.size, bus_i.addr[1:0]);
  assign p_pop = bus_i.rd && bus_i.addr[ADDR_W-1:2] == OFS_PRIO_DATA[ADDR_W-1:2]
                 && shifts(bus_i.size, bus_i.addr[1:0]);

  adc_fifo #(.DEPTH(SCAN_DEPTH), .AW(SCAN_AW)) u_scan_fifo (
    .clk(clk),
    .rst(rst),
    .clr(s_clr),
    .push(s_push),
    .din(entry),
    .pop(s_pop),
    .dout(s_dout),
    .empty(s_empty),
    .full(s_full),
    .ovf(s_ovf),
    .wr_ok(s_wr_ok),
    .fill_nxt(s_fill)
  );

  adc_fifo #(.DEPTH(PRIO_DEPTH), .AW(PRIO_AW)) u_prio_fifo (
    .clk(clk),
    .rst(rst),
    .clr(p_clr),
    .push(p_push),
    .din(entry),
    .pop(p_pop),
    .dout(p_dout),
    .empty(p_empty),
    .full(p_full),
    .ovf(p_ovf),
    .wr_ok(),
    .fill_nxt()
  );

  // ----------------------------------------------------------------
  // state register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= '0;
      q_ff.sy1 <= SY_RST;
      q_ff.sy2 <= SY_RST;
      q_ff.prv <= SY_RST;
      q_ff.cur <= LV_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rdata_o = q_ff.rdata;
  assign conv_o = q_ff.conv;
  assign scan_irq_o = q_ff.irq_flag & q_ff.irq_en;
endmodule : adc_sched

// file: src/adc_pkg.sv
/*
  constants, types and state layout of the converter scheduler and result buffers.
  assumes one 10 MHz clock, an analog core that answers each unaborted start with one done
  pulse, and a plain register port whose read data follow the read strobe by a cycle.
*/
// Functional notes
// - a prioritized start suspends a scan; the scan resumes at the suspended channel.
// - a level 1 start preempts level 2; level 2 resumes after level 1 ends.
// - a level 2 start during level 1 is held and runs after level 1.
// - a scan start during level 1 or 2 is held and runs afterwards.
// - a level 1 or level 2 start while that level is running or held is ignored.
// - scan is level 3, started by software bit or timer rising edge.
// - three readable status bits: held, prioritized active, scan active.
// - status codes 000,001,010,011,110,111 as the held/prio/scan combinations.
// - scan buffer holds 16 entries, empty after reset, entry has result, source, channel.
// - scan full flag set when all 16 entries are occupied.
// - a result into a full scan buffer is dropped and sets overflow.
// - writing the scan clear bit empties the buffer and sets empty.
// - byte reads advance the buffer only on the top byte.
// - half-word reads advance the buffer only on the upper half.
// - every word read of scan data advances the buffer.
// - scan irq flag sets when fill reaches stage count plus one.
// - irq request raised while flag and enable are both one.
// - a separate 4-entry buffer keeps prioritized results.
// - level 1 starts on external trigger falling edge when enabled.
// - level 2 starts on software bit or enabled timer rising edge.
// - a new scan start during a scan aborts and restarts it from the beginning.
// - scan visits selected channels upward from channel 0, skipping unselected.
package adc_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CH_W = 5;
  localparam int CH_N = 32;
  localparam int L1_CH_W = 3;
  localparam int RES_W = 12;
  localparam int SCAN_DEPTH = 16;
  localparam int SCAN_AW = 4;
  localparam int PRIO_DEPTH = 4;
  localparam int PRIO_AW = 2;
  localparam int STG_W = 4;
  localparam int ADDR_W = 8;
  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SCAN_CTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRIO_CTL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SCAN_SEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAGE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SCAN_DATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PRIO_DATA = 8'h1c;
  localparam int ST_SCAN = 0;
  localparam int ST_PRIO = 1;
  localparam int ST_HELD = 2;
  localparam int ST_SCAN_EMPTY_FLAG = 8;
  localparam int ST_SCAN_FULL_FLAG = 9;
  localparam int ST_SCAN_OVERFLOW_FLAG = 10;
  localparam int ST_PEMP = 12;
  localparam int ST_PFUL = 13;
  localparam int ST_POVR = 14;
  localparam int SC_START = 0;
  localparam int SC_TMR_EN = 1;
  localparam int SC_CLR = 2;
  localparam int SC_RPT = 3;
  localparam int PC_START = 0;
  localparam int PC_TMR_EN = 1;
  localparam int PC_EXT_EN = 2;
  localparam int PC_CLR = 3;
  localparam int PC_L1CH_LSB = 8;
  localparam int PC_L2CH_LSB = 16;
  localparam int IR_FLAG = 0;
  localparam int IR_EN = 4;
  localparam int D_RES_LSB = 20;
  localparam int D_SRC_LSB = 8;
  localparam int D_CH_LSB = 0;
  localparam logic [1:0] SRC_SW = 2'h0;
  localparam logic [1:0] SRC_TMR = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] LANE_TOP = 2'h3;
  // trigger pins: bit 0 external (idle high), 1 scan timer, 2 prio timer
  localparam logic [2:0] SY_RST = 3'h1;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LV_IDLE = 4'h1,
    LV_SCAN = 4'h2,
    LV_L2 = 4'h4,
    LV_L1 = 4'h8
  } adc_lvl_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
  } adc_bus_s;
  typedef struct packed {
    logic start;
    logic abort;
    logic [CH_W-1:0] ch;
  } adc_conv_req_s;
  typedef struct packed {
    logic done;
    logic [RES_W-1:0] result;
  } adc_conv_rsp_s;
  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] prv;
    logic sc_tmr_en;
    logic sc_rpt;
    logic pc_tmr_en;
    logic pc_ext_en;
    logic [L1_CH_W-1:0] l1_ch;
    logic [CH_W-1:0] l2_ch;
    logic [CH_N-1:0] sel;
    logic [STG_W-1:0] stage;
    logic irq_flag;
    logic irq_en;
    adc_lvl_e cur;
    logic l1_req;
    logic l2_req;
    logic [1:0] l2_src;
    logic scan_run;
    logic [1:0] scan_src;
    logic [CH_W-1:0] scan_ch;
    adc_conv_req_s conv;
    logic [31:0] rdata;
  } adc_st_s;
endpackage : adc_pkg

// file: verif/adc_sched_asserts.sv
/*
  port checks of the converter scheduler.
  assumes the core answers one done per unaborted start.
*/
`timescale 1ns/1ps
module adc_sched_chk
  import adc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire adc_bus_s bus_i,
  input wire logic [31:0] rdata_o,
  // trigger pins
  input wire logic ext_trig_n_i,
  input wire logic scan_tmr_i,
  input wire logic prio_tmr_i,
  // analog core
  input wire adc_conv_req_s conv_o,
  input wire adc_conv_rsp_s conv_i,
  // interrupt
  input wire logic scan_irq_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // core busy tracker
  // ----------------------------------------------------------------
  logic busy_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else if (conv_o.start) begin
      busy_ff <= 1'b1;
    end else if (conv_i.done || conv_o.abort) begin
      busy_ff <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rd_quiet_a: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
    else $error("read data outside a read");
  status_rsvd_a: assert property (bus_i.rd && bus_i.addr == OFS_STATUS
    |=> (rdata_o & 32'hffff_88f8) == 32'h0) else $error("status reserved bits set");
  reset_quiet_a: assert property ($fell(rst) |-> conv_o == '0 && !scan_irq_o)
    else $error("outputs active after reset");
  abort_pairs_a: assert property (conv_o.abort |-> conv_o.start)
    else $error("abort without new start");
  abort_busy_a: assert property (conv_o.abort |-> busy_ff)
    else $error("abort while core idle");
  start_idle_a: assert property (conv_o.start && !conv_o.abort |-> !busy_ff)
    else $error("start over a running conversion");
  ch_hold_a: assert property (!conv_o.start |-> $stable(conv_o.ch))
    else $error("channel moved without start");
  irq_rise_a: assert property ($rose(scan_irq_o) |-> $past(conv_i.done)
    || $past(conv_i.done, 2) || $past(conv_i.done, 3) || $past(bus_i.wr)
    || $past(bus_i.wr, 2)) else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(scan_irq_o) |-> $past(bus_i.wr)
    || $past(bus_i.wr, 2)) else $error("irq fell without write");
endmodule : adc_sched_chk
bind adc_sched adc_sched_chk u_chk (.clk(clk), .rst(rst), .bus_i(bus_i), .rdata_o(rdata_o),
  .ext_trig_n_i(ext_trig_n_i), .scan_tmr_i(scan_tmr_i), .prio_tmr_i(prio_tmr_i),
  .conv_o(conv_o), .conv_i(conv_i), .scan_irq_o(scan_irq_o));

// file: verif/adc_core_model.sv
/*
  behavioural analog core: one done after lat cycles per start.
  assumes lat of at least 2; abort drops the running conversion.
*/
`timescale 1ns/1ps
module adc_core_model
  import adc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion time in cycles
  input wire logic [7:0] lat,
  // scheduler side
  input wire adc_conv_req_s req,
  output adc_conv_rsp_s rsp
);
  logic busy_ff;
  logic [7:0] cnt_ff;
  logic [CH_W-1:0] ch_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h0;
      ch_ff <= '0;
      rsp <= '0;
    end else begin
      rsp.done <= 1'b0;
      // result churns outside the done cycle
      rsp.result <= ~rsp.result;
      if (req.start) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
        ch_ff <= req.ch;
      end else if (req.abort) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h1;
        if (cnt_ff == 8'h1) begin
          busy_ff <= 1'b0;
          rsp <= '{done: 1'b1, result: {7'h50, ch_ff}};
        end
      end
    end
  end
endmodule : adc_core_model

// file: verif/test_adc_priority_scheduler_scan_fifo.sv
/*
  self-checking bench of the converter scheduler.
  assumes the core model and checker sit beside the design.
*/
`timescale 1ns/1ps
module test_adc_priority_scheduler_scan_fifo;
  import adc_pkg::*;
  typedef struct packed {
    logic [31:0] sel;
    logic [3:0] stage;
    logic irq;
  } adc_row_s;
  adc_row_s rows [4] = '{'{32'h1, 4'h0, 1'b1}, '{32'h111, 4'h3, 1'b0},
    '{32'h8000_0104, 4'h2, 1'b1}, '{32'h0, 4'h0, 1'b0}};
  logic clk;
  logic rst;
  adc_bus_s bus;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [2:0] trig;
  adc_conv_req_s req;
  adc_conv_rsp_s rsp;
  logic irq;
  logic [7:0] lat;
  int num_errors;
  int check_count;
  adc_sched dut (.clk(clk), .rst(rst), .bus_i(bus), .rdata_o(rdata), .ext_trig_n_i(trig[0]),
    .scan_tmr_i(trig[1]), .prio_tmr_i(trig[2]), .conv_o(req), .conv_i(rsp), .scan_irq_o(irq));
  adc_core_model core (.clk(clk), .rst(rst), .lat(lat), .req(req), .rsp(rsp));
  // starts seen by the core, in order, with their abort bit
  logic [5:0] starts [64];
  int n_start;
  int taken;
  always @(posedge clk) begin
    if (req.start === 1'b1 && n_start < 64) begin
      starts[n_start] <= {req.abort, req.ch};
      n_start <= n_start + 1;
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task finish_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, size: SZ_WORD, wdata: v};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [1:0] sz);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, size: sz, wdata: 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task rdc(input logic [7:0] a, input logic [1:0] sz, input logic [31:0] exp);
    rd(a, sz);
    chk(d, exp);
  endtask : rdc
  task st(input logic [2:0] code);
    rd(OFS_STATUS, SZ_WORD);
    chk({29'h0, d[2:0]}, {29'h0, code});
  endtask : st
  task wait_idle;
    for (int i = 0; i < 400; i++) begin
      rd(OFS_STATUS, SZ_WORD);
      if (d[2:0] === 3'h0) break;
    end
    chk({29'h0, d[2:0]}, 32'h0);
  endtask : wait_idle
  // next logged start, so a pulse issued before the call is not missed
  task wait_start(input logic [4:0] ch, input logic ab);
    for (int i = 0; i < 400 && n_start <= taken; i++) begin
      @(posedge clk);
      #1;
    end
    chk({26'h0, starts[taken]}, {26'h0, ab, ch});
    taken++;
  endtask : wait_start
  task tog(input int k);
    @(posedge clk);
    trig[k] <= ~trig[k];
  endtask : tog
  function automatic logic [31:0] ent(input logic [4:0] ch, input logic [1:0] src);
    return {7'h50, ch, 10'h0, src, 3'h0, ch};
  endfunction : ent
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus = '0;
    trig = 3'h1;
    lat = 8'd3;
    num_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_STATUS, SZ_WORD, 32'h1100);
    rdc(8'h20, SZ_WORD, 32'h0);
    foreach (rows[r]) begin
      wr(OFS_SCAN_CTL, 32'h4);
      wr(OFS_IRQ, 32'h1);
      wr(OFS_STAGE, {28'h0, rows[r].stage});
      wr(OFS_SCAN_SEL, rows[r].sel);
      wr(OFS_SCAN_CTL, 32'h1);
      wait_idle();
      rdc(OFS_IRQ, SZ_WORD, {31'h0, rows[r].irq});
      for (int c = 0; c < 32; c++) begin
        if (rows[r].sel[c]) rdc(OFS_SCAN_DATA, SZ_WORD, ent(c[4:0], SRC_SW));
      end
      rd(OFS_STATUS, SZ_WORD);
      chk(d & 32'h100, 32'h100);
    end
    // overfilled buffer and partial reads
    wr(OFS_SCAN_CTL, 32'h4);
    wr(OFS_IRQ, 32'h11);
    wr(OFS_STAGE, 32'hf);
    wr(OFS_SCAN_SEL, 32'h3_ffff);
    wr(OFS_SCAN_CTL, 32'h1);
    wait_idle();
    rd(OFS_STATUS, SZ_WORD);
    chk(d & 32'h700, 32'h600);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_SCAN_DATA, SZ_BYTE, ent(5'h0, SRC_SW));
    rdc(OFS_SCAN_DATA, SZ_HALF, ent(5'h0, SRC_SW));
    rdc(OFS_SCAN_DATA | 8'h3, SZ_BYTE, ent(5'h0, SRC_SW));
    rdc(OFS_SCAN_DATA | 8'h2, SZ_HALF, ent(5'h1, SRC_SW));
    rdc(OFS_SCAN_DATA | 8'h1, SZ_BYTE, ent(5'h2, SRC_SW));
    rdc(OFS_SCAN_DATA, SZ_WORD, ent(5'h2, SRC_SW));
    rdc(OFS_SCAN_DATA, SZ_WORD, ent(5'h3, SRC_SW));
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ, 32'h1);
    rdc(OFS_IRQ, SZ_WORD, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_SCAN_CTL, 32'h4);
    rdc(OFS_STATUS, SZ_WORD, 32'h1100);
    // preemption chain with slow core
    lat <= 8'd30;
    taken = n_start;
    wr(OFS_SCAN_SEL, 32'hf);
    wr(OFS_PRIO_CTL, 32'h9_0304);
    wr(OFS_SCAN_CTL, 32'h1);
    wait_start(5'h0, 1'b0);
    wait_start(5'h1, 1'b0);
    wr(OFS_SCAN_CTL, 32'h1);
    wait_start(5'h0, 1'b1);
    wait_start(5'h1, 1'b0);
    st(3'h1);
    wr(OFS_PRIO_CTL, 32'h9_0305);
    wait_start(5'h9, 1'b1);
    st(3'h3);
    wr(OFS_PRIO_CTL, 32'h9_0305);
    tog(0);
    wait_start(5'h3, 1'b1);
    st(3'h7);
    tog(0);
    wait_start(5'h9, 1'b0);
    wait_start(5'h1, 1'b0);
    wait_start(5'h2, 1'b0);
    wait_start(5'h3, 1'b0);
    wait_idle();
    rdc(OFS_PRIO_DATA, SZ_WORD, ent(5'h3, SRC_EXT));
    rdc(OFS_PRIO_DATA, SZ_WORD, ent(5'h9, SRC_SW));
    wr(OFS_PRIO_CTL, 32'h8);
    wr(OFS_SCAN_CTL, 32'h4);
    // held requests from trigger pins
    wr(OFS_SCAN_SEL, 32'h1);
    wr(OFS_PRIO_CTL, 32'h7_0506);
    wr(OFS_SCAN_CTL, 32'h2);
    tog(0);
    wait_start(5'h5, 1'b0);
    st(3'h2);
    tog(2);
    repeat (6) @(posedge clk);
    st(3'h6);
    tog(1);
    repeat (6) @(posedge clk);
    st(3'h7);
    wait_start(5'h7, 1'b0);
    wait_start(5'h0, 1'b0);
    wait_idle();
    rdc(OFS_PRIO_DATA, SZ_WORD, ent(5'h5, SRC_EXT));
    rdc(OFS_PRIO_DATA, SZ_WORD, ent(5'h7, SRC_TMR));
    rdc(OFS_SCAN_DATA, SZ_WORD, ent(5'h0, SRC_TMR));
    // repeat mode: wraps to the first channel until repeat is written off
    wr(OFS_SCAN_CTL, 32'h9);
    wait_start(5'h0, 1'b0);
    wait_start(5'h0, 1'b0);
    wr(OFS_SCAN_CTL, 32'h0);
    wait_idle();
    rdc(OFS_SCAN_DATA, SZ_WORD, ent(5'h0, SRC_SW));
    rdc(OFS_SCAN_DATA, SZ_WORD, ent(5'h0, SRC_SW));
    rdc(OFS_STATUS, SZ_WORD, 32'h1100);
    finish_test();
  end
  initial begin
    #(100 * 40000);
    num_errors++;
    finish_test();
  end
endmodule : test_adc_priority_scheduler_scan_fifo
